/* File: rssae_regs.vh */
// register offsets, field positions and reset values of the receive status sampler
`ifndef RSSAE_REGS_VH
`define RSSAE_REGS_VH

// register byte offsets
`define RSSAE_CTRL_OFS        5'h00
`define RSSAE_ECHO_EN_OFS     5'h04
`define RSSAE_STATUS_OFS      5'h08
`define RSSAE_IRQ_STAT_OFS    5'h0C
`define RSSAE_IRQ_MASK_OFS    5'h10
`define RSSAE_DA_OFS          5'h14

// address decode width
`define RSSAE_ADDR_W          5

// control register fields
`define RSSAE_CTRL_ECHO_MASTER 0

// status register fields (sampled flops)
`define RSSAE_ST_OVERRUN      0
`define RSSAE_ST_ECHO_OFF     1
`define RSSAE_ST_TX_RUN       2
`define RSSAE_ST_TX_FULL      3
`define RSSAE_ST_BUS_REQ      4
`define RSSAE_ST_FRAMING      5

// interrupt status / mask fields
`define RSSAE_IRQ_OVERRUN     0
`define RSSAE_IRQ_FRAMING     1
`define RSSAE_IRQ_ECHO_DONE   2
`define RSSAE_IRQ_ECHO_ABORT  3
`define RSSAE_IRQ_W           4

// reset values
`define RSSAE_CTRL_RST        1'h1
`define RSSAE_ECHO_EN_RST     16'h0000
`define RSSAE_IRQ_MASK_RST    4'h0

// bus responses
`define RSSAE_RESP_OKAY       2'h0
`define RSSAE_RESP_DECERR     2'h3

// line counts
`define RSSAE_LINES           16
`define RSSAE_LINES_PER_CARD  8

`endif

/* File: rssae_sampler.v */
// receive status sampler and auto-echo qualifier with an axi4-lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "rssae_regs.vh"

// Behaviour
// R1: a line flags overrun when a character arrives while data-available is still set
// R2: each card selects its line's overrun by scan index; both cards are ORed
// R3: sample pulse sets the overrun flop on overrun, clears it otherwise
// R4: per-line echo enable (parameter bit 15) is selected by the receive scan index
// R5: echo flop stored inverted: set when echo disabled, cleared when enabled
// R6: transmitter scanner flop set while that scanner runs, cleared when stopped
// R7: holding-empty flags muxed by scan index; flop set when full, cleared when empty
// R8: bus request flop set while a memory transfer is requested or in progress
// R9: a line flags framing error when its character lacks a valid stop bit
// R10: card framing errors ORed; sample sets the framing flop on error, else clears
// R11: echoed characters are retransmitted on their own line and still stored in silo
// R12: on echo lines, framing and overrun flags are stored with the character
// R13: echo needs no bus request, a running transmitter scanner and holding-register room
// R14: echo is blocked during memory transfers since transmit data lines are shared
// R15: echo qualifies on echo flop clear, bus clear, scanner set, holding clear
// R16: status is captured by the first sequencer pulse, before decide-next
// R17: on echo grant the transmit line select follows the receive scan index
// R18: echo enabled but unqualified aborts next clock, ending sequence, restarting scanner
// R19: the six status flops hold their values between sample pulses
module rssae_sampler (
   // clock and reset
   input  wire        clk_i,
   input  wire        sys_rst_i,
   // axi4-lite write address
   input  wire        s_axi_awvalid_i,
   output reg         s_axi_awready_o,
   input  wire [31:0] s_axi_awaddr_i,
   input  wire [2:0]  s_axi_awprot_i,
   // axi4-lite write data
   input  wire        s_axi_wvalid_i,
   output reg         s_axi_wready_o,
   input  wire [31:0] s_axi_wdata_i,
   input  wire [3:0]  s_axi_wstrb_i,
   // axi4-lite write response
   output reg         s_axi_bvalid_o,
   input  wire        s_axi_bready_i,
   output reg  [1:0]  s_axi_bresp_o,
   // axi4-lite read address
   input  wire        s_axi_arvalid_i,
   output reg         s_axi_arready_o,
   input  wire [31:0] s_axi_araddr_i,
   input  wire [2:0]  s_axi_arprot_i,
   // axi4-lite read data
   output reg         s_axi_rvalid_o,
   input  wire        s_axi_rready_i,
   output reg  [31:0] s_axi_rdata_o,
   output reg  [1:0]  s_axi_rresp_o,
   // per-line receivers and transmitters
   input  wire [15:0] rx_char_arrive_i,
   input  wire [15:0] rx_stop_bit_ok_i,
   input  wire [15:0] tx_holding_empty_i,
   output reg  [15:0] line_data_available_o,
   // scanners and sequencer
   input  wire [3:0]  receive_scan_index_i,
   input  wire [3:0]  tx_scan_index_i,
   input  wire        tx_scanner_running_i,
   input  wire        direct_memory_transfer_i,
   input  wire        sample_status_i,
   input  wire        decide_next_step_i,
   // echo and silo control
   output reg         echo_go_o,
   output reg         echo_abort_o,
   output reg         restart_scan_o,
   output reg  [3:0]  tx_line_select_o,
   output reg         silo_load_o,
   output reg         silo_overrun_o,
   output reg         silo_framing_o,
   // interrupt
   output reg         irq_o
);

   // per-line receiver flags
   reg  [15:0] line_overrun;
   reg  [15:0] line_framing_error;

   // sampled status flops
   reg         st_overrun;
   reg         st_echo_off;
   reg         st_tx_run;
   reg         st_tx_full;
   reg         st_bus_req;
   reg         st_framing;

   // software registers
   reg         ctrl_echo_master;
   reg  [15:0] line_echo_enable;
   reg  [3:0]  irq_stat;
   reg  [3:0]  irq_mask;

   // bus slave state
   reg         aw_held;
   reg         w_held;
   reg  [4:0]  aw_addr;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;

   wire        wr_fire;
   wire        rd_take;
   wire [4:0]  rd_addr;
   reg  [31:0] next_rdata;
   reg  [1:0]  next_rresp;

   // card selection
   wire [2:0]  card_index;
   wire        card1_sel;
   wire        card0_overrun;
   wire        card1_overrun;
   wire        card0_framing;
   wire        card1_framing;
   wire        selected_overrun;
   wire        selected_framing_error;
   wire        selected_echo_enable;
   wire        selected_tx_full;

   // decision terms
   wire        echo_conditions_ok;
   wire        echo_grant;
   wire        echo_deny;
   wire [3:0]  irq_events;
   wire [3:0]  irq_clear;
   wire        da_clear;
   wire [15:0] scan_sel;

   assign card_index = receive_scan_index_i[2:0];
   assign card1_sel  = receive_scan_index_i[3];
   assign scan_sel   = 16'h0001 << receive_scan_index_i;

   // clearing data-available of the serviced line
   assign da_clear = decide_next_step_i & ~echo_deny;

   // per-line overrun, framing and data-available flags
   genvar gi;
   generate
      for (gi = 0; gi < `RSSAE_LINES; gi = gi + 1) begin : g_line
         always @(posedge clk_i) begin
            if (sys_rst_i) begin
               line_overrun[gi]          <= 1'b0;
               line_framing_error[gi]    <= 1'b0;
               line_data_available_o[gi] <= 1'b0;
            end else if (rx_char_arrive_i[gi]) begin
               // arrival wins over a same-cycle clear of data-available
               line_overrun[gi]          <= line_data_available_o[gi]; // R1
               line_framing_error[gi]    <= ~rx_stop_bit_ok_i[gi]; // R9
               line_data_available_o[gi] <= 1'b1;
            end else if (da_clear && scan_sel[gi]) begin
               line_data_available_o[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // card-level selectors ORed together
   assign card0_overrun = line_overrun[{1'b0, card_index}] & ~card1_sel; // R2
   assign card1_overrun = line_overrun[{1'b1, card_index}] & card1_sel; // R2
   assign selected_overrun = card0_overrun | card1_overrun; // R2
   assign card0_framing = line_framing_error[{1'b0, card_index}] & ~card1_sel; // R10
   assign card1_framing = line_framing_error[{1'b1, card_index}] & card1_sel; // R10
   assign selected_framing_error = card0_framing | card1_framing; // R10

   // 16-way selectors
   assign selected_echo_enable = line_echo_enable[receive_scan_index_i] & ctrl_echo_master; // R4
   assign selected_tx_full     = ~tx_holding_empty_i[receive_scan_index_i]; // R7

   // status sampling on the sequencer's first pulse
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         st_overrun  <= 1'b0;
         st_echo_off <= 1'b1;
         st_tx_run   <= 1'b0;
         st_tx_full  <= 1'b0;
         st_bus_req  <= 1'b0;
         st_framing  <= 1'b0;
      end else if (sample_status_i) begin // R16 R19
         st_overrun  <= selected_overrun; // R3
         st_echo_off <= ~selected_echo_enable; // R5
         st_tx_run   <= tx_scanner_running_i; // R6
         st_tx_full  <= selected_tx_full; // R7
         st_bus_req  <= direct_memory_transfer_i; // R8 R14
         st_framing  <= selected_framing_error; // R10
      end
   end

   // echo qualification from the sampled flops
   assign echo_conditions_ok = ~st_bus_req & st_tx_run & ~st_tx_full; // R13 R14
   assign echo_grant = decide_next_step_i & ~st_echo_off & echo_conditions_ok; // R15
   assign echo_deny  = decide_next_step_i & ~st_echo_off & ~echo_conditions_ok; // R18

   // sequencer-facing outputs, one clock after decide-next
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         echo_go_o        <= 1'b0;
         echo_abort_o     <= 1'b0;
         restart_scan_o   <= 1'b0;
         silo_load_o      <= 1'b0;
         silo_overrun_o   <= 1'b0;
         silo_framing_o   <= 1'b0;
         tx_line_select_o <= 4'h0;
      end else begin
         echo_go_o      <= echo_grant; // R11
         echo_abort_o   <= echo_deny; // R18
         restart_scan_o <= decide_next_step_i; // R18
         silo_load_o    <= da_clear; // R11
         if (da_clear) begin
            silo_overrun_o <= st_overrun; // R12
            silo_framing_o <= st_framing; // R12
         end
         if (echo_grant) begin
            tx_line_select_o <= receive_scan_index_i; // R17
         end else begin
            tx_line_select_o <= tx_scan_index_i;
         end
      end
   end

   // sticky interrupt events, set wins over write-one-to-clear
   assign irq_events = {echo_deny,
                        echo_grant,
                        sample_status_i & selected_framing_error,
                        sample_status_i & selected_overrun};

   assign irq_clear = (wr_fire && aw_addr == `RSSAE_IRQ_STAT_OFS && w_strb[0]) ?
                      w_data[`RSSAE_IRQ_W-1:0] : 4'h0;

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         irq_stat <= 4'h0;
         irq_o    <= 1'b0;
      end else begin
         irq_stat <= (irq_stat & ~irq_clear) | irq_events;
         irq_o    <= |(irq_stat & irq_mask);
      end
   end

   // write-side register updates
   assign wr_fire = aw_held & w_held & ~s_axi_bvalid_o;

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         ctrl_echo_master <= `RSSAE_CTRL_RST;
         line_echo_enable <= `RSSAE_ECHO_EN_RST;
         irq_mask         <= `RSSAE_IRQ_MASK_RST;
      end else if (wr_fire) begin
         case (aw_addr)
            `RSSAE_CTRL_OFS: begin
               if (w_strb[0]) begin
                  ctrl_echo_master <= w_data[`RSSAE_CTRL_ECHO_MASTER];
               end
            end
            `RSSAE_ECHO_EN_OFS: begin
               if (w_strb[0]) begin
                  line_echo_enable[7:0] <= w_data[7:0];
               end
               if (w_strb[1]) begin
                  line_echo_enable[15:8] <= w_data[15:8];
               end
            end
            `RSSAE_IRQ_MASK_OFS: begin
               if (w_strb[0]) begin
                  irq_mask <= w_data[`RSSAE_IRQ_W-1:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // write address, data and response channels
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         s_axi_awready_o <= 1'b1;
         s_axi_wready_o  <= 1'b1;
         s_axi_bvalid_o  <= 1'b0;
         s_axi_bresp_o   <= `RSSAE_RESP_OKAY;
         aw_held         <= 1'b0;
         w_held          <= 1'b0;
         aw_addr         <= 5'h00;
         w_data          <= 32'h00000000;
         w_strb          <= 4'h0;
      end else begin
         if (s_axi_awready_o && s_axi_awvalid_i) begin
            aw_addr         <= s_axi_awaddr_i[`RSSAE_ADDR_W-1:0];
            aw_held         <= 1'b1;
            s_axi_awready_o <= 1'b0;
            if (s_axi_awaddr_i[31:`RSSAE_ADDR_W] != 27'h0000000) begin
               aw_addr <= 5'h1F;
            end
         end
         if (s_axi_wready_o && s_axi_wvalid_i) begin
            w_data         <= s_axi_wdata_i;
            w_strb         <= s_axi_wstrb_i;
            w_held         <= 1'b1;
            s_axi_wready_o <= 1'b0;
         end
         if (wr_fire) begin
            aw_held        <= 1'b0;
            w_held         <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            case (aw_addr)
               `RSSAE_CTRL_OFS, `RSSAE_ECHO_EN_OFS, `RSSAE_STATUS_OFS,
               `RSSAE_IRQ_STAT_OFS, `RSSAE_IRQ_MASK_OFS, `RSSAE_DA_OFS: begin
                  s_axi_bresp_o <= `RSSAE_RESP_OKAY;
               end
               default: begin
                  s_axi_bresp_o <= `RSSAE_RESP_DECERR;
               end
            endcase
         end
         if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o  <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
         end
      end
   end

   // read data selection
   assign rd_take = s_axi_arready_o & s_axi_arvalid_i;
   assign rd_addr = s_axi_araddr_i[`RSSAE_ADDR_W-1:0];

   always @* begin
      next_rdata = 32'h00000000;
      next_rresp = `RSSAE_RESP_OKAY;
      if (s_axi_araddr_i[31:`RSSAE_ADDR_W] != 27'h0000000) begin
         next_rresp = `RSSAE_RESP_DECERR;
      end else begin
         case (rd_addr)
            `RSSAE_CTRL_OFS: begin
               next_rdata[`RSSAE_CTRL_ECHO_MASTER] = ctrl_echo_master;
            end
            `RSSAE_ECHO_EN_OFS: begin
               next_rdata[15:0] = line_echo_enable;
            end
            `RSSAE_STATUS_OFS: begin
               next_rdata[`RSSAE_ST_OVERRUN]  = st_overrun;
               next_rdata[`RSSAE_ST_ECHO_OFF] = st_echo_off;
               next_rdata[`RSSAE_ST_TX_RUN]   = st_tx_run;
               next_rdata[`RSSAE_ST_TX_FULL]  = st_tx_full;
               next_rdata[`RSSAE_ST_BUS_REQ]  = st_bus_req;
               next_rdata[`RSSAE_ST_FRAMING]  = st_framing;
            end
            `RSSAE_IRQ_STAT_OFS: begin
               next_rdata[`RSSAE_IRQ_W-1:0] = irq_stat;
            end
            `RSSAE_IRQ_MASK_OFS: begin
               next_rdata[`RSSAE_IRQ_W-1:0] = irq_mask;
            end
            `RSSAE_DA_OFS: begin
               next_rdata[15:0] = line_data_available_o;
            end
            default: begin
               next_rresp = `RSSAE_RESP_DECERR;
            end
         endcase
      end
   end

   // read address and data channels
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         s_axi_arready_o <= 1'b1;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= 32'h00000000;
         s_axi_rresp_o   <= `RSSAE_RESP_OKAY;
      end else begin
         if (rd_take) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b1;
            s_axi_rdata_o   <= next_rdata;
            s_axi_rresp_o   <= next_rresp;
         end
         if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o  <= 1'b0;
            s_axi_arready_o <= 1'b1;
         end
      end
   end

endmodule // rssae_sampler
`default_nettype wire

/* File: rssae_sampler_sva.sv */
// assertion checker for the receive status sampler and echo qualifier
`timescale 1ns/100ps
`default_nettype none
module rssae_sampler_sva (
   // clock and reset
   input wire logic        clk_i,
   input wire logic        sys_rst_i,
   // line and sequencer inputs
   input wire logic [15:0] rx_char_arrive_i,
   input wire logic [15:0] rx_stop_bit_ok_i,
   input wire logic [15:0] tx_holding_empty_i,
   input wire logic [3:0]  receive_scan_index_i,
   input wire logic [3:0]  tx_scan_index_i,
   input wire logic        tx_scanner_running_i,
   input wire logic        direct_memory_transfer_i,
   input wire logic        sample_status_i,
   input wire logic        decide_next_step_i,
   // design outputs
   input wire logic [15:0] line_data_available_o,
   input wire logic        echo_go_o,
   input wire logic        echo_abort_o,
   input wire logic        restart_scan_o,
   input wire logic [3:0]  tx_line_select_o,
   input wire logic        silo_load_o,
   input wire logic        silo_overrun_o,
   input wire logic        silo_framing_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   logic [15:0] h_fe;
   logic [15:0] h_ov;
   logic        s_fe, s_ov, s_run, s_full, s_bus;
   wire         qual_ok = s_run && !s_full && !s_bus;
   // per-line error flags as the receivers record them
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         h_fe <= 16'h0000;
         h_ov <= 16'h0000;
      end else begin
         h_fe <= (h_fe & ~rx_char_arrive_i) | (~rx_stop_bit_ok_i & rx_char_arrive_i);
         h_ov <= (h_ov & ~rx_char_arrive_i) | (line_data_available_o & rx_char_arrive_i);
      end
   end
   always_ff @(posedge clk_i) begin
      if (sample_status_i) begin
         {s_fe, s_ov, s_run, s_full, s_bus} <= {h_fe[receive_scan_index_i], h_ov[receive_scan_index_i],
            tx_scanner_running_i, !tx_holding_empty_i[receive_scan_index_i], direct_memory_transfer_i};
      end
   end
   sequence s_walk;
      sample_status_i ##1 decide_next_step_i;
   endsequence
   sequence s_answer;
      restart_scan_o && (silo_load_o || echo_abort_o);
   endsequence
   property p_walk;
      s_walk |=> s_answer;
   endproperty
   property p_restart;
      restart_scan_o |-> $past(decide_next_step_i);
   endproperty
   property p_go_qual;
      echo_go_o |-> qual_ok && !echo_abort_o && silo_load_o;
   endproperty
   property p_abort;
      echo_abort_o |-> !qual_ok && !silo_load_o && !echo_go_o;
   endproperty
   property p_silo_err;
      silo_load_o |-> silo_overrun_o == s_ov && silo_framing_o == s_fe;
   endproperty
   property p_sel_echo;
      echo_go_o |-> tx_line_select_o == $past(receive_scan_index_i);
   endproperty
   property p_sel_norm;
      !echo_go_o && !$past(sys_rst_i) |-> tx_line_select_o == $past(tx_scan_index_i);
   endproperty
   property p_arrive;
      rx_char_arrive_i != 16'h0000 |=>
         (line_data_available_o & $past(rx_char_arrive_i)) == $past(rx_char_arrive_i);
   endproperty
   property p_flags_hold;
      !silo_load_o |-> $stable(silo_overrun_o) && $stable(silo_framing_o);
   endproperty
   a_walk: assert property (p_walk) else $error("decide gave no answer");
   a_restart: assert property (p_restart) else $error("restart without decide");
   a_go_qual: assert property (p_go_qual) else $error("echo granted unqualified");
   a_abort: assert property (p_abort) else $error("abort while qualified");
   a_silo_err: assert property (p_silo_err) else $error("silo error flags wrong");
   a_sel_echo: assert property (p_sel_echo) else $error("echo line select wrong");
   a_sel_norm: assert property (p_sel_norm) else $error("normal line select wrong");
   a_arrive: assert property (p_arrive) else $error("data available not set");
   a_flags_hold: assert property (p_flags_hold) else $error("silo flags moved");
endmodule // rssae_sampler_sva
bind rssae_sampler rssae_sampler_sva sva_u (.*);
`default_nettype wire

/* File: rssae_uart_model.sv */
// behavioural model of the sixteen line receivers and transmitters
`timescale 1ns/100ps
`default_nettype none
module rssae_uart_model (
   // stimulus
   input wire logic        clk_i,
   input wire logic        fire_i,
   input wire logic [3:0]  line_i,
   input wire logic        bad_stop_i,
   input wire logic [15:0] full_mask_i,
   // line pins
   output logic [15:0]     rx_char_arrive_o,
   output logic [15:0]     rx_stop_bit_ok_o,
   output logic [15:0]     tx_holding_empty_o
);
   wire logic [15:0] sel = 16'h0001 << line_i;
   logic [15:0]      arrive_q = 16'h0000;
   logic [15:0]      stop_ok_q = 16'hFFFF;
   assign tx_holding_empty_o = ~full_mask_i;
   assign rx_char_arrive_o = arrive_q;
   assign rx_stop_bit_ok_o = stop_ok_q;
   // stop flag only meaningful with an arrival, toggles otherwise
   always @(posedge clk_i) begin
      arrive_q <= fire_i ? sel : 16'h0000;
      stop_ok_q <= fire_i ? (bad_stop_i ? ~sel : 16'hFFFF) : ~stop_ok_q;
   end
endmodule // rssae_uart_model
`default_nettype wire

/* File: rssae_sampler_tb.sv */
// self-checking testbench of the receive status sampler
`timescale 1ns/100ps
`default_nettype none
module rssae_sampler_tb;
   typedef struct packed {logic [3:0] ln; logic [5:0] f;} rssae_row_t;
   logic clk_i = 1'b0, sys_rst_i = 1'b1;
   logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
   logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
   logic [31:0] s_axi_awaddr_i = 32'h0, s_axi_wdata_i = 32'h0, s_axi_araddr_i = 32'h0;
   logic [2:0] s_axi_awprot_i = 3'h0, s_axi_arprot_i = 3'h0;
   logic [3:0] s_axi_wstrb_i = 4'hF, receive_scan_index_i = 4'h0, tx_scan_index_i = 4'h0;
   logic tx_scanner_running_i = 1'b0, direct_memory_transfer_i = 1'b0;
   logic sample_status_i = 1'b0, decide_next_step_i = 1'b0;
   logic fire = 1'b0, bad_stop = 1'b0;
   logic [3:0] fire_line = 4'h0;
   logic [15:0] full_mask = 16'h0, da = 16'h0;
   wire logic [15:0] rx_char_arrive_i, rx_stop_bit_ok_i, tx_holding_empty_i;
   logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
   logic echo_go_o, echo_abort_o, restart_scan_o, silo_load_o, silo_overrun_o, silo_framing_o, irq_o;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
   logic [31:0] s_axi_rdata_o, d;
   logic [15:0] line_data_available_o;
   logic [3:0] tx_line_select_o, ln;
   logic en, run, full, bus, fe, ov, go;
   integer fails = 0, checked = 0, cyc = 0;
   // line, {echo enable, scanner running, holding full, bus request, framing, overrun}
   rssae_row_t rows [7] = '{'{4'h0, 6'b110000}, '{4'h3, 6'b110011}, '{4'h7, 6'b100000},
      '{4'h8, 6'b111000}, '{4'hC, 6'b110100}, '{4'hF, 6'b010000}, '{4'h9, 6'b000011}};
   rssae_sampler dut_u (.*);
   rssae_uart_model uart_u (.clk_i(clk_i), .fire_i(fire), .line_i(fire_line), .bad_stop_i(bad_stop),
      .full_mask_i(full_mask), .rx_char_arrive_o(rx_char_arrive_i), .rx_stop_bit_ok_o(rx_stop_bit_ok_i),
      .tx_holding_empty_o(tx_holding_empty_i));
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   task automatic stop_test;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic axw(input logic [31:0] a, input logic [31:0] v, output logic [1:0] q);
      @(posedge clk_i);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= v;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      do begin
         @(posedge clk_i);
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      end while (s_axi_bvalid_o !== 1'b1);
      q = s_axi_bresp_o;
      s_axi_bready_i <= 1'b0;
   endtask
   task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk_i);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      do begin
         @(posedge clk_i);
         if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      end while (s_axi_rvalid_o !== 1'b1);
      d = s_axi_rdata_o;
      s_axi_rready_i <= 1'b0;
      chk(n, e, d);
      chk({n, "_resp"}, er, s_axi_rresp_o);
   endtask
   task automatic shoot(input logic [3:0] l, input logic b);
      @(posedge clk_i);
      fire <= 1'b1;
      fire_line <= l;
      bad_stop <= b;
      @(posedge clk_i);
      fire <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic seq;
      @(posedge clk_i);
      sample_status_i <= 1'b1;
      @(posedge clk_i);
      sample_status_i <= 1'b0;
      decide_next_step_i <= 1'b1;
      @(posedge clk_i);
      decide_next_step_i <= 1'b0;
      #1;
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails++;
         stop_test;
      end
   end
   initial begin
      repeat (10) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         {en, run, full, bus, fe, ov} = rows[i].f;
         ln = rows[i].ln;
         go = en & run & !full & !bus;
         axw(32'h4, {31'h0, en} << ln, r);
         chk("echo_en_bresp", 2'h0, r);
         full_mask <= full ? 16'h1 << ln : 16'h0;
         tx_scanner_running_i <= run;
         direct_memory_transfer_i <= bus;
         receive_scan_index_i <= ln;
         tx_scan_index_i <= ~ln;
         repeat (ov + 1) shoot(ln, fe);
         da[ln] = 1'b1;
         rdc("data_avail", 32'h14, {16'h0, da}, 2'h0);
         chk("data_avail_line", 1'b1, d[ln]);
         seq;
         chk("echo_go", go, echo_go_o);
         chk("echo_abort", en & !go, echo_abort_o);
         chk("silo_load", !(en & !go), silo_load_o);
         chk("restart", 1'b1, restart_scan_o);
         chk("tx_select", go ? ln : tx_scan_index_i, tx_line_select_o);
         if (!(en & !go)) chk("silo_flags", {ov, fe}, {silo_overrun_o, silo_framing_o});
         if (!(en & !go)) da[ln] = 1'b0;
         @(posedge clk_i);
         tx_scanner_running_i <= !run;
         direct_memory_transfer_i <= !bus;
         full_mask <= ~full_mask;
         rdc("status", 32'h8, {26'h0, fe, bus, full, run, !en, ov}, 2'h0);
      end
      rdc("irq_stat", 32'hC, 32'hF, 2'h0);
      chk("irq_masked", 1'b0, irq_o);
      axw(32'h10, 32'hF, r);
      @(posedge clk_i);
      #1 chk("irq_on", 1'b1, irq_o);
      axw(32'hC, 32'hF, r);
      @(posedge clk_i);
      #1 chk("irq_off", 1'b0, irq_o);
      rdc("irq_clear", 32'hC, 32'h0, 2'h0);
      rdc("unmapped", 32'h18, 32'h0, 2'h3);
      axw(32'h1C, 32'h1, r);
      chk("unmapped_bresp", 2'h3, r);
      axw(32'h0, 32'h0, r);
      axw(32'h4, 32'h200, r);
      seq;
      chk("master_off_go", 1'b0, echo_go_o);
      chk("master_off_abort", 1'b0, echo_abort_o);
      chk("master_off_load", 1'b1, silo_load_o);
      @(posedge clk_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rdc("ctrl_reset", 32'h0, 32'h1, 2'h0);
      rdc("echo_en_reset", 32'h4, 32'h0, 2'h0);
      rdc("mask_reset", 32'h10, 32'h0, 2'h0);
      rdc("da_reset", 32'h14, 32'h0, 2'h0);
      stop_test;
   end
endmodule // rssae_sampler_tb
`default_nettype wire
